// ===== core/ccr_map.svh
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

// Register offsets of the configuration bank and its neighbours
`define CCR_OFF_CMD       8'h05
`define CCR_OFF_MASK1     8'h06
`define CCR_OFF_MASK2     8'h07
`define CCR_OFF_CFG1      8'h08
`define CCR_OFF_CFG2      8'h09
`define CCR_OFF_REF_HI    8'h0a
`define CCR_OFF_REF_LO    8'h0b

// Reset values
`define CCR_RST_CFG1      8'h28
`define CCR_RST_CFG2      8'hf3
`define CCR_RST_REF_HI    8'h32
`define CCR_RST_REF_LO    3'h0
`define CCR_RST_MASK      8'h00
`define CCR_RST_CODE      11'h190

// First configuration byte fields
`define CCR_CFG1_PGDLY_HI 7
`define CCR_CFG1_PGDLY_LO 6
`define CCR_CFG1_MASKALL  5
`define CCR_CFG1_BIDLY_HI 4
`define CCR_CFG1_BIDLY_LO 3
`define CCR_CFG1_WMASK    8'hf8

// Second configuration byte fields
`define CCR_CFG2_SERVO_HI 7
`define CCR_CFG2_SERVO_LO 6
`define CCR_CFG2_DIS_SRV  5
`define CCR_CFG2_DIS_OFF  4
`define CCR_CFG2_NO_UVP   3
`define CCR_CFG2_LATCH    2
`define CCR_CFG2_AUX5     1
`define CCR_CFG2_AUXLR    0

// Command byte field
`define CCR_CMD_LOAD      1

// Reference code limits
`define CCR_CODE_MAX      11'h780

// Delay times in microseconds and clock rate
`define CCR_CLK_MHZ       125
`define CCR_PG_DLY1_US    250
`define CCR_PG_DLY2_US    1000
`define CCR_PG_DLY3_US    4000
`define CCR_BI_DLY0_US    1000
`define CCR_BI_DLY1_US    1250
`define CCR_BI_DLY2_US    1500
`define CCR_BI_DLY3_US    3000

// Defaults for block timing of the analog side
`define CCR_SERVO_BASE    100
`define CCR_HICCUP_OFF    4096

`endif

// ===== core/ccr_pkg.sv
package ccr_pkg;

  // Delay counter width, wide enough for the 4 ms setting
  localparam int unsigned CCR_DLY_W = 19;

  typedef logic [CCR_DLY_W-1:0] ccr_delay_type;
  typedef logic [10:0]          ccr_code_type;

  // Fault response states, one-hot
  typedef enum logic [2:0] {
    CCR_RUN     = 3'b001,
    CCR_HICCUP  = 3'b010,
    CCR_LATCHED = 3'b100
  } ccr_fault_state_type;

endpackage

// ===== core/ccr_delay_timer.sv
`timescale 1ns/100ps
`default_nettype none

module ccr_delay_timer
  import ccr_pkg::*;
(
  input  wire logic          clock,     // System clock
  input  wire logic          resetn,    // Synchronous reset, active low
  input  wire logic          cond,      // Internal good condition
  input  wire ccr_delay_type delay_cyc, // Selected delay in cycles
  output var  logic          ind_r      // Delayed indicator
);

  ccr_delay_type cnt_r;
  logic          done;

  // Restarts on every drop so a glitch never shortens the delay
  assign done = (cnt_r >= delay_cyc);

  // Count up while the condition holds, drive after full delay
  always_ff @(posedge clock) begin
    if (!resetn || !cond) begin
      cnt_r <= '0;
      ind_r <= 1'b0;
    end else if (done) begin
      ind_r <= 1'b1; // R18
    end else begin
      cnt_r <= cnt_r + ccr_delay_type'(1); // R18
    end
  end

endmodule

`default_nettype wire

// ===== core/ccr_regs.sv
// Operation
// R1: PG delay field selects 0/0.25/1/4 ms
// R2: Bias delay field selects 1/1.25/1.5/3 ms
// R3: Mask-all bit forces every mask bit
// R4: Servo field scales step period 1/2/4/8
// R5: Bit 5 enables discharge during downward servo
// R6: Bit 4 enables discharge while converter disabled
// R7: Bit 3 disables undervoltage protection
// R8: Bit 2 selects hiccup or latch-off response
// R9: Same bit governs sync-error response
// R10: Bit 1 enables auxiliary 5 V converter
// R11: Bit 0 enables auxiliary linear regulator
// R12: Code is 11 bits, high byte here
// R13: Code maps linearly, output eight times reference
// R14: Codes from 0x780 saturate at maximum
// R15: Reference code resets to 0x190
// R16: New code applies on load; load reads zero
// R17: Mask bit suppresses its event's interrupt
// R18: Indicator delay counted after good condition
// R19: Unused first-byte bits read zero
`timescale 1ns/100ps
`include "ccr_map.svh"
`default_nettype none

module ccr_regs
  import ccr_pkg::*;
#(
  parameter int unsigned PG_DLY1_CYC    = `CCR_PG_DLY1_US * `CCR_CLK_MHZ,
  parameter int unsigned PG_DLY2_CYC    = `CCR_PG_DLY2_US * `CCR_CLK_MHZ,
  parameter int unsigned PG_DLY3_CYC    = `CCR_PG_DLY3_US * `CCR_CLK_MHZ,
  parameter int unsigned BI_DLY0_CYC    = `CCR_BI_DLY0_US * `CCR_CLK_MHZ,
  parameter int unsigned BI_DLY1_CYC    = `CCR_BI_DLY1_US * `CCR_CLK_MHZ,
  parameter int unsigned BI_DLY2_CYC    = `CCR_BI_DLY2_US * `CCR_CLK_MHZ,
  parameter int unsigned BI_DLY3_CYC    = `CCR_BI_DLY3_US * `CCR_CLK_MHZ,
  parameter int unsigned SERVO_BASE_CYC = `CCR_SERVO_BASE,
  parameter int unsigned HICCUP_OFF_CYC = `CCR_HICCUP_OFF
) (
  input  wire logic         clock,          // System clock, 125 MHz
  input  wire logic         resetn,         // Synchronous reset, active low
  input  wire logic [7:0]   reg_addr,       // Register offset
  input  wire logic [7:0]   reg_wdata,      // Write data
  input  wire logic         reg_wr,         // Write strobe, one cycle
  input  wire logic         reg_rd,         // Read strobe, one cycle
  output var  logic [7:0]   reg_rdata_r,    // Read data, one cycle later
  input  wire logic         pg_cond,        // Converter in regulation
  input  wire logic         bias_cond,      // Bias rail in regulation
  input  wire logic [7:0]   event_one,      // Event flags, first byte
  input  wire logic [7:0]   event_two,      // Event flags, second byte
  input  wire logic         main_enable,    // Main converter enabled
  input  wire logic         servo_down,     // Servo stepping downward
  input  wire logic         uvp_low,        // Output below UV threshold
  input  wire logic         sync_error,     // Sync input out of range
  input  wire logic         aux5_manual,    // Manual start of 5 V rail
  input  wire logic         auxlr_manual,   // Manual start of regulator
  output var  logic         power_good_indicator_r, // Delayed good
  output var  logic         bias_good_indicator_r,  // Delayed bias good
  output var  logic         irq_r,          // Unmasked event present
  output var  logic         servo_step_r,   // Servo step pulse
  output var  logic         discharge_r,    // Discharge resistor on
  output var  logic         converter_off_r,// Fault holds converter off
  output var  logic         restart_r,      // Hiccup restart pulse
  output var  logic         aux5_enable_r,  // Auxiliary 5 V enable
  output var  logic         auxlr_enable_r, // Aux regulator enable
  output var  logic [10:0]  voltage_reference_code_r // Applied code
);

  // Register storage
  logic [7:0]          cfg1_r;
  logic [7:0]          cfg2_r;
  logic [7:0]          ref_hi_r;
  logic [2:0]          ref_lo_r;
  logic [7:0]          mask1_r;
  logic [7:0]          mask2_r;
  ccr_code_type        active_code_r;
  ccr_fault_state_type fault_state_r;
  ccr_fault_state_type fault_state_nxt;
  logic [19:0]         hiccup_cnt_r;
  logic [15:0]         servo_cnt_r;

  // Write decode
  logic wr_cfg1;
  logic wr_cfg2;
  logic wr_ref_hi;
  logic wr_ref_lo;
  logic wr_mask1;
  logic wr_mask2;
  logic load_cmd;

  assign wr_cfg1   = reg_wr && (reg_addr == `CCR_OFF_CFG1);
  assign wr_cfg2   = reg_wr && (reg_addr == `CCR_OFF_CFG2);
  assign wr_ref_hi = reg_wr && (reg_addr == `CCR_OFF_REF_HI);
  assign wr_ref_lo = reg_wr && (reg_addr == `CCR_OFF_REF_LO);
  assign wr_mask1  = reg_wr && (reg_addr == `CCR_OFF_MASK1);
  assign wr_mask2  = reg_wr && (reg_addr == `CCR_OFF_MASK2);
  assign load_cmd  = reg_wr && (reg_addr == `CCR_OFF_CMD)
                     && reg_wdata[`CCR_CMD_LOAD]; // R16

  // Field extraction
  logic [1:0] pg_sel;
  logic [1:0] bi_sel;
  logic [1:0] servo_sel;
  logic       mask_all;
  logic       dis_servo;
  logic       dis_off;
  logic       no_uvp;
  logic       latch_mode;

  assign pg_sel     = cfg1_r[`CCR_CFG1_PGDLY_HI:`CCR_CFG1_PGDLY_LO];
  assign bi_sel     = cfg1_r[`CCR_CFG1_BIDLY_HI:`CCR_CFG1_BIDLY_LO];
  assign mask_all   = cfg1_r[`CCR_CFG1_MASKALL];
  assign servo_sel  = cfg2_r[`CCR_CFG2_SERVO_HI:`CCR_CFG2_SERVO_LO];
  assign dis_servo  = cfg2_r[`CCR_CFG2_DIS_SRV];
  assign dis_off    = cfg2_r[`CCR_CFG2_DIS_OFF];
  assign no_uvp     = cfg2_r[`CCR_CFG2_NO_UVP];
  assign latch_mode = cfg2_r[`CCR_CFG2_LATCH];

  // Configuration and mask registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cfg1_r  <= `CCR_RST_CFG1;
      cfg2_r  <= `CCR_RST_CFG2;
      mask1_r <= `CCR_RST_MASK;
      mask2_r <= `CCR_RST_MASK;
    end else begin
      if (wr_cfg1)
        cfg1_r <= reg_wdata & `CCR_CFG1_WMASK; // R19
      if (wr_cfg2)
        cfg2_r <= reg_wdata;
      if (wr_mask1)
        mask1_r <= reg_wdata;
      if (wr_mask2)
        mask2_r <= reg_wdata;
    end
  end

  // Staged reference code; the converter sees it only on load
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ref_hi_r      <= `CCR_RST_REF_HI; // R15
      ref_lo_r      <= `CCR_RST_REF_LO;
      active_code_r <= `CCR_RST_CODE; // R15
    end else begin
      if (wr_ref_hi)
        ref_hi_r <= reg_wdata; // R12
      if (wr_ref_lo)
        ref_lo_r <= reg_wdata[2:0]; // R12
      if (load_cmd)
        active_code_r <= {ref_hi_r, ref_lo_r}; // R16
    end
  end

  // Clamp above the top characterised code; linear below it
  ccr_code_type code_clamped;

  assign code_clamped = (active_code_r >= `CCR_CODE_MAX) ?
                        `CCR_CODE_MAX : active_code_r; // R13 R14

  always_ff @(posedge clock) begin
    if (!resetn)
      voltage_reference_code_r <= `CCR_RST_CODE;
    else
      voltage_reference_code_r <= code_clamped; // R13 R14
  end

  // Read mux; load bit and unmapped offsets return zero
  logic [7:0] rd_mux;

  assign rd_mux =
    (reg_addr == `CCR_OFF_CFG1)   ? cfg1_r : // R19
    (reg_addr == `CCR_OFF_CFG2)   ? cfg2_r :
    (reg_addr == `CCR_OFF_REF_HI) ? ref_hi_r :
    (reg_addr == `CCR_OFF_REF_LO) ? {5'h00, ref_lo_r} :
    (reg_addr == `CCR_OFF_MASK1)  ? mask1_r :
    (reg_addr == `CCR_OFF_MASK2)  ? mask2_r :
    8'h00; // R16

  always_ff @(posedge clock) begin
    if (!resetn)
      reg_rdata_r <= 8'h00;
    else if (reg_rd)
      reg_rdata_r <= rd_mux;
  end

  // Delay selection tables
  ccr_delay_type pg_dly;
  ccr_delay_type bi_dly;

  assign pg_dly =
    (pg_sel == 2'h0) ? '0 :
    (pg_sel == 2'h1) ? CCR_DLY_W'(PG_DLY1_CYC) :
    (pg_sel == 2'h2) ? CCR_DLY_W'(PG_DLY2_CYC) :
    CCR_DLY_W'(PG_DLY3_CYC); // R1

  assign bi_dly =
    (bi_sel == 2'h0) ? CCR_DLY_W'(BI_DLY0_CYC) :
    (bi_sel == 2'h1) ? CCR_DLY_W'(BI_DLY1_CYC) :
    (bi_sel == 2'h2) ? CCR_DLY_W'(BI_DLY2_CYC) :
    CCR_DLY_W'(BI_DLY3_CYC); // R2

  // Indicator delay timers
  ccr_delay_timer u_pg_timer (
    .clock     (clock),
    .resetn    (resetn),
    .cond      (pg_cond),
    .delay_cyc (pg_dly),
    .ind_r     (power_good_indicator_r)
  );

  ccr_delay_timer u_bias_timer (
    .clock     (clock),
    .resetn    (resetn),
    .cond      (bias_cond),
    .delay_cyc (bi_dly),
    .ind_r     (bias_good_indicator_r)
  );

  // Effective masks and interrupt request
  logic [7:0] eff_mask1;
  logic [7:0] eff_mask2;
  logic       irq_any;

  assign eff_mask1 = mask1_r | {8{mask_all}}; // R3
  assign eff_mask2 = mask2_r | {8{mask_all}}; // R3
  assign irq_any   = |(event_one & ~eff_mask1)
                   | |(event_two & ~eff_mask2); // R17

  always_ff @(posedge clock) begin
    if (!resetn)
      irq_r <= 1'b0;
    else
      irq_r <= irq_any;
  end

  // Servo step period: base width shifted by the selected scale
  logic [15:0] servo_period;
  logic        servo_wrap;

  assign servo_period = 16'(SERVO_BASE_CYC) << servo_sel; // R4
  assign servo_wrap   = (servo_cnt_r >= servo_period - 16'h0001);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      servo_cnt_r  <= 16'h0000;
      servo_step_r <= 1'b0;
    end else begin
      servo_cnt_r  <= servo_wrap ? 16'h0000 : servo_cnt_r + 16'h0001;
      servo_step_r <= servo_wrap; // R4
    end
  end

  // Fault response: undervoltage and sync errors share one policy
  logic fault_evt;
  logic hiccup_done;

  assign fault_evt   = (uvp_low && !no_uvp) || sync_error; // R7 R9
  assign hiccup_done = (hiccup_cnt_r == 20'h00000);

  always_comb begin
    fault_state_nxt = fault_state_r;
    case (fault_state_r)
      CCR_RUN: begin
        if (fault_evt)
          fault_state_nxt = latch_mode ? CCR_LATCHED : CCR_HICCUP; // R8 R9
      end
      CCR_HICCUP: begin
        if (hiccup_done)
          fault_state_nxt = CCR_RUN; // R8
      end
      CCR_LATCHED: begin
        fault_state_nxt = CCR_LATCHED; // R8
      end
      default: begin
        fault_state_nxt = CCR_RUN;
      end
    endcase
  end

  // Hiccup off-time counter loaded on entry
  always_ff @(posedge clock) begin
    if (!resetn)
      hiccup_cnt_r <= 20'h00000;
    else if (fault_state_r == CCR_RUN)
      hiccup_cnt_r <= 20'(HICCUP_OFF_CYC);
    else if (!hiccup_done)
      hiccup_cnt_r <= hiccup_cnt_r - 20'h00001;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      fault_state_r   <= CCR_RUN;
      converter_off_r <= 1'b0;
      restart_r       <= 1'b0;
    end else begin
      fault_state_r   <= fault_state_nxt;
      converter_off_r <= (fault_state_nxt != CCR_RUN);
      restart_r       <= (fault_state_r == CCR_HICCUP)
                         && (fault_state_nxt == CCR_RUN); // R8
    end
  end

  // Discharge resistor control; fault shutdown counts as disabled
  logic conv_disabled;
  logic discharge_nxt;

  assign conv_disabled = !main_enable || converter_off_r;
  assign discharge_nxt = (dis_servo && servo_down && !conv_disabled) // R5
                       || (dis_off && conv_disabled); // R6

  // Auxiliary rails start from the config bit or a manual start
  always_ff @(posedge clock) begin
    if (!resetn) begin
      discharge_r    <= 1'b0;
      aux5_enable_r  <= 1'b0;
      auxlr_enable_r <= 1'b0;
    end else begin
      discharge_r    <= discharge_nxt;
      aux5_enable_r  <= cfg2_r[`CCR_CFG2_AUX5] || aux5_manual; // R10
      auxlr_enable_r <= cfg2_r[`CCR_CFG2_AUXLR] || auxlr_manual; // R11
    end
  end

endmodule

`default_nettype wire

// ===== sim/ccr_regs_sva.sv
`timescale 1ns/100ps
`default_nettype none

module ccr_regs_sva (
  input wire logic        clock,                   // Clock
  input wire logic        resetn,                  // Reset
  input wire logic [7:0]  reg_addr,                // Offset
  input wire logic [7:0]  reg_wdata,               // Data
  input wire logic        reg_wr,                  // Write
  input wire logic        reg_rd,                  // Read
  input wire logic [7:0]  reg_rdata_r,             // Read data
  input wire logic        pg_cond,                 // Good in
  input wire logic        sync_error,              // Sync fault
  input wire logic        aux5_manual,             // Manual 5 V
  input wire logic        auxlr_manual,            // Manual reg
  input wire logic        power_good_indicator_r,  // Good out
  input wire logic        irq_r,                   // Interrupt
  input wire logic        servo_step_r,            // Step
  input wire logic        converter_off_r,         // Held off
  input wire logic        restart_r,               // Retry
  input wire logic        aux5_enable_r,           // 5 V on
  input wire logic        auxlr_enable_r,          // Reg on
  input wire logic [10:0] voltage_reference_code_r // Code
);
  logic [7:0] cfg1_r;
  logic [7:0] cfg2_r;
  wire  logic load_w;

  // Shadow of both config bytes, updated on the bank's own edge
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cfg1_r <= 8'h28;
      cfg2_r <= 8'hf3;
    end else if (reg_wr && reg_addr == 8'h08) begin
      cfg1_r <= reg_wdata;
    end else if (reg_wr && reg_addr == 8'h09) begin
      cfg2_r <= reg_wdata;
    end
  end

  // Load command strobe
  assign load_w = reg_wr && reg_addr == 8'h05 && reg_wdata[1];

  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);

  // Good condition present on the edge that set the indicator;
  // a zero delay lets it rise one edge after the condition
  sequence good_held_s;
    $past(pg_cond);
  endsequence
  // Sync fault taken while running
  sequence sync_hit_s;
    sync_error && !converter_off_r;
  endsequence

  a_cfg1_read: assert property (
    reg_rd && reg_addr == 8'h08 |=> reg_rdata_r == ($past(cfg1_r) & 8'hf8))
    else $error("config byte one read back wrong");
  a_cmd_zero: assert property (
    reg_rd && (reg_addr == 8'h05 || reg_addr == 8'h04) |=> reg_rdata_r == 0)
    else $error("command or reserved read not zero");
  a_load_only: assert property (
    $changed(voltage_reference_code_r) |-> $past(load_w, 2))
    else $error("code changed without load");
  a_code_sat: assert property (
    voltage_reference_code_r <= 11'h780)
    else $error("code above saturation");
  a_pg_rise: assert property (
    $rose(power_good_indicator_r) |-> good_held_s)
    else $error("indicator rose too early");
  a_pg_fall: assert property (
    !pg_cond |=> !power_good_indicator_r)
    else $error("indicator did not fall");
  a_mask_all: assert property (
    cfg1_r[5] && $past(cfg1_r[5]) |-> !irq_r)
    else $error("interrupt through global mask");
  a_aux_follow: assert property ($past(resetn) |->
    aux5_enable_r == $past(cfg2_r[1] || aux5_manual) &&
    auxlr_enable_r == $past(cfg2_r[0] || auxlr_manual))
    else $error("aux enable mismatch");
  a_sync_off: assert property (sync_hit_s |=> converter_off_r)
    else $error("sync fault not acted on");
  a_latch_hold: assert property (
    converter_off_r && cfg2_r[2] |=> converter_off_r)
    else $error("latched off released");
  a_retry_mode: assert property (
    restart_r |-> !cfg2_r[2] && $past(converter_off_r))
    else $error("restart outside hiccup");
  a_servo_gap: assert property (
    servo_step_r |=> !servo_step_r [*3])
    else $error("servo steps too close");
endmodule

bind ccr_regs ccr_regs_sva u_sva (
  .clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r,
  .pg_cond, .sync_error, .aux5_manual, .auxlr_manual,
  .power_good_indicator_r, .irq_r, .servo_step_r, .converter_off_r,
  .restart_r, .aux5_enable_r, .auxlr_enable_r, .voltage_reference_code_r
);

`default_nettype wire

// ===== sim/converter_config_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ccr_map.svh"

module converter_config_regs_tb;
  logic        clock, resetn, reg_wr, reg_rd, pg_cond, bias_cond;
  logic        main_enable, servo_down, uvp_low, sync_error, aux5_manual;
  logic        auxlr_manual, power_good_indicator_r, bias_good_indicator_r;
  logic        irq_r, servo_step_r, discharge_r, converter_off_r, restart_r;
  logic        aux5_enable_r, auxlr_enable_r;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata_r, event_one, event_two;
  logic [10:0] voltage_reference_code_r;
  int          fails, cmp_count, cyc, n, pn, bn;
  // Edges from condition to indicator; zero: long settings stay low
  int          pd[4] = '{1, 6, 21, 81};
  int          bd[4] = '{21, 26, 0, 0};
  logic [7:0]  dc[4] = '{8'h10, 8'h00, 8'h20, 8'h00};

  // Short delays keep the run small; servo base, hiccup time and the
  // two long bias settings keep their real lengths
  ccr_regs #(
    .PG_DLY1_CYC(5), .PG_DLY2_CYC(20), .PG_DLY3_CYC(80), .BI_DLY0_CYC(20),
    .BI_DLY1_CYC(25)
  ) uut (
    .clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r,
    .pg_cond, .bias_cond, .event_one, .event_two, .main_enable, .servo_down,
    .uvp_low, .sync_error, .aux5_manual, .auxlr_manual,
    .power_good_indicator_r, .bias_good_indicator_r, .irq_r, .servo_step_r,
    .discharge_r, .converter_off_r, .restart_r, .aux5_enable_r,
    .auxlr_enable_r, .voltage_reference_code_r
  );

  // Verdict, reached from the end of the tests or the cycle ceiling
  task automatic close_out;
    if (fails == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [10:0] e, s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic idle(input int k);
    repeat (k) @(negedge clock);
  endtask

  // Strobes last one cycle; next call starts a cycle later
  task automatic wr(input logic [7:0] a, d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, e);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    chk("rdata", 11'(e), 11'(reg_rdata_r));
  endtask

  // Always advances at least one cycle, so a pulse is not counted twice
  task automatic wait_hi(ref logic s);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (s !== 1'b1 && n < 5000);
  endtask

  task automatic ld(input logic [10:0] c, e);
    wr(8'h0a, c[10:3]);
    wr(8'h0b, {5'h00, c[2:0]});
    wr(8'h05, 8'h02);
    idle(2);
    chk("code", e, voltage_reference_code_r);
  endtask

  task automatic do_reset;
    resetn = 1'b0;
    idle(6);
    resetn = 1'b1;
  endtask

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Ceiling on run length
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end

  initial begin
    {resetn, reg_wr, reg_rd, pg_cond, bias_cond, main_enable, servo_down,
     uvp_low, sync_error, aux5_manual, auxlr_manual, reg_addr, reg_wdata,
     event_one, event_two} = '0;
    do_reset();
    rd(8'h08, 8'h28);
    rd(8'h09, 8'hf3);
    rd(8'h0a, 8'h32);
    rd(8'h05, 8'h00);
    rd(8'h04, 8'h00);
    chk("code", 11'h190, voltage_reference_code_r);
    chk("aux", 11'h3, 11'({aux5_enable_r, auxlr_enable_r}));
    wr(8'h08, 8'hff);
    rd(8'h08, 8'hf8);
    // Indicator delay for every field value
    for (int i = 0; i < 4; i++) begin
      wr(8'h08, {i[1:0], 1'b1, i[1:0], 3'h0});
      pg_cond = 1'b1;
      bias_cond = 1'b1;
      {n, pn, bn} = '0;
      while ((pn == 0 || bn == 0) && n < 200) begin
        @(negedge clock);
        n++;
        if (pn == 0 && power_good_indicator_r === 1'b1) pn = n;
        if (bn == 0 && bias_good_indicator_r === 1'b1) bn = n;
      end
      chk("pg delay", 11'(pd[i]), 11'(pn));
      chk("bias delay", 11'(bd[i]), 11'(bn));
      pg_cond = 1'b0;
      bias_cond = 1'b0;
      idle(1);
      chk("pg fall", 11'h0, 11'(power_good_indicator_r));
    end
    // Global override first, then per-bit masks
    event_one = 8'h01;
    event_two = 8'h20;
    idle(3);
    chk("irq", 11'h0, 11'(irq_r));
    wr(8'h08, 8'h00);
    idle(2);
    chk("irq", 11'h1, 11'(irq_r));
    wr(8'h06, 8'h01);
    wr(8'h07, 8'h20);
    idle(2);
    chk("irq", 11'h0, 11'(irq_r));
    // Code staged but not applied until the load command
    wr(8'h0a, 8'h60);
    idle(3);
    chk("code", 11'h190, voltage_reference_code_r);
    ld(11'h300, 11'h300);
    ld(11'h0f0, 11'h0f0);
    ld(11'h77f, 11'h77f);
    ld(11'h780, 11'h780);
    ld(11'h7ff, 11'h780);
    rd(8'h0b, 8'h07);
    // Servo period; skip one interval so the new scale has settled
    for (int i = 0; i < 4; i++) begin
      wr(8'h09, {i[1:0], 6'h03});
      wait_hi(servo_step_r);
      wait_hi(servo_step_r);
      wait_hi(servo_step_r);
      chk("servo", 11'(`CCR_SERVO_BASE << i), 11'(n));
    end
    // Discharge when off, and during downward servo
    for (int i = 0; i < 4; i++) begin
      main_enable = i[1];
      servo_down = i[1];
      wr(8'h09, dc[i]);
      idle(2);
      chk("discharge", 11'(i[0] == 0), 11'(discharge_r));
    end
    chk("aux", 11'h0, 11'({aux5_enable_r, auxlr_enable_r}));
    {aux5_manual, auxlr_manual} = 2'b11;
    idle(2);
    chk("aux", 11'h3, 11'({aux5_enable_r, auxlr_enable_r}));
    // Hiccup on undervoltage, then latch-off on a sync fault
    wr(8'h09, 8'h03);
    uvp_low = 1'b1;
    idle(2);
    chk("off", 11'h1, 11'(converter_off_r));
    uvp_low = 1'b0;
    wait_hi(restart_r);
    chk("retry", 11'h2, 11'({restart_r, converter_off_r}));
    wr(8'h09, 8'h07);
    sync_error = 1'b1;
    idle(1);
    sync_error = 1'b0;
    idle(40);
    chk("latched", 11'h1, 11'(converter_off_r));
    do_reset();
    rd(8'h0a, 8'h32);
    wr(8'h09, 8'h0b);
    uvp_low = 1'b1;
    idle(4);
    chk("no uvp", 11'h0, 11'(converter_off_r));
    uvp_low = 1'b0;
    close_out();
  end
endmodule

`default_nettype wire
